// [src/tch_pkg.sv]
// Purpose: shared constants for the touch report framer
// Assumes: 100 MHz system clock, byte-wide endpoint stream
// Notes: byte positions count from the report identifier at 0
package tch_pkg;

  // ===========================================================
  // endpoints and device identity
  localparam logic [7:0] EP_GENERIC_IN_ADDR = 8'h81;
  localparam logic [7:0] EP_GENERIC_OUT_ADDR = 8'h02;
  localparam logic [7:0] EP_TOUCH_IN_ADDR = 8'h83;
  localparam logic [1:0] DIGITIZER_IN_EP_COUNT = 2'h1;
  localparam logic [1:0] DIGITIZER_OUT_EP_COUNT = 2'h0;
  localparam logic FULL_SPEED = 1'b1;
  localparam int LINK_RATE_MBPS = 12;

  // ===========================================================
  // report layout
  localparam logic [7:0] REPORT_ID_TOUCH = 8'h01;
  localparam logic [5:0] BYTE_REPORT_ID = 6'h00;
  localparam logic [5:0] BYTE_FIRST_SLOT = 6'h01;
  localparam logic [5:0] BYTE_LAST_SLOT = 6'h37;
  localparam logic [5:0] BYTE_SCAN_LO = 6'h38;
  localparam logic [5:0] BYTE_SCAN_HI = 6'h39;
  localparam logic [5:0] BYTE_COUNT = 6'h3A;
  localparam logic [2:0] SLOTS_PER_REPORT = 3'h5;
  localparam logic [5:0] SLOTS_PER_REPORT_W6 = 6'h05;
  localparam logic [2:0] LAST_SLOT_IDX = 3'h4;

  // ===========================================================
  // offsets inside one 11-byte slot
  localparam logic [3:0] OFF_ID = 4'h0;
  localparam logic [3:0] OFF_X_LO = 4'h1;
  localparam logic [3:0] OFF_X_HI = 4'h2;
  localparam logic [3:0] OFF_X2_LO = 4'h3;
  localparam logic [3:0] OFF_X2_HI = 4'h4;
  localparam logic [3:0] OFF_Y_LO = 4'h5;
  localparam logic [3:0] OFF_Y_HI = 4'h6;
  localparam logic [3:0] OFF_Y2_LO = 4'h7;
  localparam logic [3:0] OFF_Y2_HI = 4'h8;
  localparam logic [3:0] OFF_WIDTH = 4'h9;
  localparam logic [3:0] OFF_HEIGHT = 4'hA;
  localparam logic [3:0] OFF_LAST = 4'hA;

  // ===========================================================
  // scan time base
  localparam int CLK_HZ = 100000000;
  localparam int SCAN_TICK_HZ = 10000;
  localparam int SCAN_TICK_CYCLES = CLK_HZ / SCAN_TICK_HZ;

  typedef enum logic {TCH_IDLE, TCH_SEND} tch_state_e;

endpackage

// [src/tch_report_framer.sv]
// Purpose: builds digitizer input reports for the touch interrupt-in endpoint
// Assumes: touch table answers o_touch_idx combinationally in the same cycle
// Notes: one frame is one or more 59-byte reports, five touches each
`timescale 1ns/1ps
module tch_report_framer
  import tch_pkg::*;
#(
  parameter int SCAN_CYCLES = tch_pkg::SCAN_TICK_CYCLES,
  parameter logic [3:0] VER_MAJOR = 4'h1,
  parameter logic [3:0] VER_MINOR = 4'h0,
  parameter logic [7:0] BUILD_BCD = 8'h01
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // frame request
  input wire logic i_frame_start,
  input wire logic [4:0] i_touch_count,
  input wire logic i_touch_geometry_enable,
  // touch table lookup
  input wire logic [4:0] i_touch_id,
  input wire logic i_in_detect,
  input wire logic [11:0] i_x,
  input wire logic [11:0] i_y,
  input wire logic [11:0] i_x2,
  input wire logic [11:0] i_y2,
  input wire logic [7:0] i_width,
  input wire logic [7:0] i_height,
  output logic [4:0] o_touch_idx,
  // byte stream toward the endpoint buffer
  output logic [7:0] o_ep_data,
  output logic o_ep_valid,
  input wire logic i_ep_ready,
  output logic o_ep_report_end,
  output logic o_ep_frame_end,
  output logic [7:0] o_ep_addr,
  output logic o_busy,
  // static device description
  output logic [7:0] o_generic_in_addr,
  output logic [7:0] o_generic_out_addr,
  output logic [1:0] o_digitizer_in_eps,
  output logic [1:0] o_digitizer_out_eps,
  output logic o_full_speed,
  output logic o_ctrl_ep_enable,
  output logic [15:0] o_version
);

  // ===========================================================
  // state
  tch_state_e state_r;
  tch_state_e state_nxt;
  logic [5:0] byte_r;
  logic [3:0] off_r;
  logic [5:0] base_r;
  logic [5:0] tidx_r;
  logic [5:0] count_r;
  logic geom_r;
  logic [15:0] scan_r;
  logic [15:0] frame_scan_r;
  logic [$clog2(SCAN_CYCLES)-1:0] pre_r;

  // ===========================================================
  // scan time base
  localparam logic [$clog2(SCAN_CYCLES)-1:0] PRE_LAST = ($clog2(SCAN_CYCLES))'(SCAN_CYCLES - 1);
  wire pre_wrap = (pre_r == PRE_LAST);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pre_r <= '0;
      scan_r <= 16'h0000;
    end
    else
    begin
      pre_r <= pre_wrap ? '0 : pre_r + 1'b1;
      if (pre_wrap)
      begin
        scan_r <= scan_r + 16'h0001;
      end
    end
  end

  // ===========================================================
  // byte decode
  wire load = (state_r == TCH_SEND) && (!o_ep_valid || i_ep_ready);
  wire accept = (state_r == TCH_IDLE) && i_frame_start;
  wire in_slots = (byte_r >= BYTE_FIRST_SLOT) && (byte_r <= BYTE_LAST_SLOT);
  wire at_count = (byte_r == BYTE_COUNT);
  wire last_rpt = ((base_r + SLOTS_PER_REPORT_W6) >= count_r);
  wire slot_active = (tidx_r < count_r);
  wire off_wrap = (off_r == OFF_LAST);
  wire [7:0] slot_byte;
  wire [7:0] count_byte = last_rpt ? {2'b00, count_r} : 8'h00;
  logic [7:0] byte_nxt;

  tch_slot_byte u_slot (
    .i_offset(off_r),
    .i_active(slot_active),
    .i_geom_en(geom_r),
    .i_touch_id(i_touch_id),
    .i_in_detect(i_in_detect),
    .i_x(i_x),
    .i_y(i_y),
    .i_x2(i_x2),
    .i_y2(i_y2),
    .i_width(i_width),
    .i_height(i_height),
    .o_byte(slot_byte)
  );

  always_comb
  begin
    byte_nxt = 8'h00;
    if (byte_r == BYTE_REPORT_ID)
    begin
      byte_nxt = REPORT_ID_TOUCH;
    end
    else if (in_slots)
    begin
      byte_nxt = slot_byte;
    end
    else if (byte_r == BYTE_SCAN_LO)
    begin
      byte_nxt = frame_scan_r[7:0];
    end
    else if (byte_r == BYTE_SCAN_HI)
    begin
      byte_nxt = frame_scan_r[15:8];
    end
    else
    begin
      byte_nxt = count_byte;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TCH_IDLE: state_nxt = accept ? TCH_SEND : TCH_IDLE;
      TCH_SEND: state_nxt = (load && at_count && last_rpt) ? TCH_IDLE : TCH_SEND;
      default: state_nxt = TCH_IDLE;
    endcase
  end

  // ===========================================================
  // frame sequencing
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_r <= TCH_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      count_r <= 6'h00;
      geom_r <= 1'b0;
      frame_scan_r <= 16'h0000;
    end
    else if (accept)
    begin
      count_r <= {1'b0, i_touch_count};
      geom_r <= i_touch_geometry_enable;
      frame_scan_r <= scan_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || accept)
    begin
      byte_r <= BYTE_REPORT_ID;
      off_r <= OFF_ID;
      base_r <= 6'h00;
      tidx_r <= 6'h00;
    end
    else if (load && at_count)
    begin
      byte_r <= BYTE_REPORT_ID;
      off_r <= OFF_ID;
      base_r <= base_r + SLOTS_PER_REPORT_W6;
      tidx_r <= base_r + SLOTS_PER_REPORT_W6;
    end
    else if (load)
    begin
      byte_r <= byte_r + 6'h01;
      if (in_slots)
      begin
        off_r <= off_wrap ? OFF_ID : off_r + 4'h1;
        if (off_wrap)
        begin
          tidx_r <= tidx_r + 6'h01;
        end
      end
    end
  end

  // ===========================================================
  // output stage
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_ep_valid <= 1'b0;
      o_ep_data <= 8'h00;
      o_ep_report_end <= 1'b0;
      o_ep_frame_end <= 1'b0;
    end
    else if (load)
    begin
      o_ep_valid <= 1'b1;
      o_ep_data <= byte_nxt;
      o_ep_report_end <= at_count;
      o_ep_frame_end <= at_count && last_rpt;
    end
    else if (i_ep_ready)
    begin
      o_ep_valid <= 1'b0;
      o_ep_report_end <= 1'b0;
      o_ep_frame_end <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_touch_idx <= 5'h00;
      o_busy <= 1'b0;
    end
    else
    begin
      o_touch_idx <= state_nxt == TCH_IDLE ? 5'h00 : o_touch_idx;
      o_busy <= (state_nxt == TCH_SEND);
      if (accept)
      begin
        o_touch_idx <= 5'h00;
      end
      else if (load && at_count)
      begin
        o_touch_idx <= 5'(base_r + SLOTS_PER_REPORT_W6);
      end
      else if (load && in_slots && off_wrap)
      begin
        o_touch_idx <= 5'(tidx_r + 6'h01);
      end
    end
  end

  // ===========================================================
  // static description
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_ep_addr <= 8'h00;
      o_generic_in_addr <= 8'h00;
      o_generic_out_addr <= 8'h00;
      o_digitizer_in_eps <= 2'h0;
      o_digitizer_out_eps <= 2'h0;
      o_full_speed <= 1'b0;
      o_ctrl_ep_enable <= 1'b0;
      o_version <= 16'h0000;
    end
    else
    begin
      o_ep_addr <= EP_TOUCH_IN_ADDR;
      o_generic_in_addr <= EP_GENERIC_IN_ADDR;
      o_generic_out_addr <= EP_GENERIC_OUT_ADDR;
      o_digitizer_in_eps <= DIGITIZER_IN_EP_COUNT;
      o_digitizer_out_eps <= DIGITIZER_OUT_EP_COUNT;
      o_full_speed <= FULL_SPEED;
      o_ctrl_ep_enable <= 1'b1;
      o_version <= {VER_MAJOR, VER_MINOR, BUILD_BCD};
    end
  end

endmodule

// [src/tch_slot_byte.sv]
// Purpose: selects one byte of a touch slot from its offset
// Assumes: positions already scaled to 12 bits
// Notes: inactive slot reads all zero
`timescale 1ns/1ps
module tch_slot_byte
  import tch_pkg::*;
(
  input wire logic [3:0] i_offset,
  input wire logic i_active,
  input wire logic i_geom_en,
  input wire logic [4:0] i_touch_id,
  input wire logic i_in_detect,
  input wire logic [11:0] i_x,
  input wire logic [11:0] i_y,
  input wire logic [11:0] i_x2,
  input wire logic [11:0] i_y2,
  input wire logic [7:0] i_width,
  input wire logic [7:0] i_height,
  output logic [7:0] o_byte
);

  logic [7:0] sel;

  always_comb
  begin
    sel = 8'h00;
    case (i_offset)
      OFF_ID: sel = {i_touch_id, 2'b00, i_in_detect};
      OFF_X_LO: sel = i_x[7:0];
      OFF_X_HI: sel = {4'h0, i_x[11:8]};
      OFF_Y_LO: sel = i_y[7:0];
      OFF_Y_HI: sel = {4'h0, i_y[11:8]};
      OFF_X2_LO: sel = i_geom_en ? i_x2[7:0] : 8'h00;
      OFF_X2_HI: sel = i_geom_en ? {4'h0, i_x2[11:8]} : 8'h00;
      OFF_Y2_LO: sel = i_geom_en ? i_y2[7:0] : 8'h00;
      OFF_Y2_HI: sel = i_geom_en ? {4'h0, i_y2[11:8]} : 8'h00;
      OFF_WIDTH: sel = i_geom_en ? i_width : 8'h00;
      OFF_HEIGHT: sel = i_geom_en ? i_height : 8'h00;
      default: sel = 8'h00;
    endcase
  end

  assign o_byte = i_active ? sel : 8'h00;

endmodule

// [verification/tch_host_model.sv]
// Purpose: polling host sink on the touch in endpoint
// Assumes: ready moves 1 ns after the clock edge
// Notes: stalled host takes one byte in three cycles
`timescale 1ns/1ps
module tch_host_model (
  input wire logic i_clk_sys,
  input wire logic i_stall,
  output logic o_ready
);
  logic [1:0] ph_r = 2'h0;
  always @(posedge i_clk_sys)
  begin
    ph_r <= #1 (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
  end
  assign o_ready = !i_stall || ph_r == 2'h0;
endmodule

// [verification/tch_report_framer_properties.sv]
// Purpose: port-level checks of the touch report framer
// Assumes: one clock, synchronous active-high reset
// Notes: pos_r tracks the byte position taken by the sink
`timescale 1ns/1ps
module tch_report_framer_properties
  import tch_pkg::*;
#(
  parameter logic [3:0] VER_MAJOR = 4'h1,
  parameter logic [3:0] VER_MINOR = 4'h0,
  parameter logic [7:0] BUILD_BCD = 8'h01
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_frame_start,
  input wire logic i_touch_geometry_enable,
  input wire logic i_ep_ready,
  input wire logic [7:0] o_ep_data,
  input wire logic o_ep_valid,
  input wire logic o_ep_report_end,
  input wire logic [7:0] o_ep_addr,
  input wire logic o_busy,
  input wire logic [7:0] o_generic_in_addr,
  input wire logic [7:0] o_generic_out_addr,
  input wire logic [1:0] o_digitizer_in_eps,
  input wire logic [1:0] o_digitizer_out_eps,
  input wire logic o_full_speed,
  input wire logic [15:0] o_version
);
  import tch_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // byte position and latched layout
  logic [5:0] pos_r;
  logic geom_r;
  wire logic take = o_ep_valid && i_ep_ready;
  wire logic [5:0] pos_nxt = o_ep_report_end ? 6'h00 : pos_r + 6'h01;
  wire logic [5:0] pm1 = pos_r - 6'h01;
  wire logic [3:0] off = 4'(pm1 % 6'h0B);
  wire logic slot = o_ep_valid && pos_r >= BYTE_FIRST_SLOT && pos_r <= BYTE_LAST_SLOT;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset) pos_r <= 6'h00;
    else if (take) pos_r <= pos_nxt;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_frame_start && !o_busy) geom_r <= i_touch_geometry_enable;
  end
  // ==========================================================
  // assertions
  AST_EP_ADDRS: assert property (!$past(i_reset) |-> o_ep_addr == EP_TOUCH_IN_ADDR
    && o_generic_in_addr == EP_GENERIC_IN_ADDR && o_generic_out_addr == EP_GENERIC_OUT_ADDR)
    else $error("endpoint address wrong");
  AST_DIG_EPS: assert property (!$past(i_reset) |-> o_digitizer_in_eps == 2'h1
    && o_digitizer_out_eps == 2'h0) else $error("digitizer endpoint count wrong");
  AST_FULL_SPEED: assert property (!$past(i_reset) |-> o_full_speed)
    else $error("full speed flag low");
  AST_VERSION: assert property (!$past(i_reset) |->
    o_version == {VER_MAJOR, VER_MINOR, BUILD_BCD}) else $error("version wrong");
  AST_START: assert property (!o_busy && !o_ep_valid && i_frame_start |=>
    o_busy ##1 (o_ep_valid && o_ep_data == REPORT_ID_TOUCH)) else $error("start answer wrong");
  AST_ID_FIRST: assert property (o_ep_valid && pos_r == 6'h00 |->
    o_ep_data == REPORT_ID_TOUCH) else $error("report id wrong");
  AST_END_AT_58: assert property (o_ep_valid && o_ep_report_end |-> pos_r == BYTE_COUNT)
    else $error("report end misplaced");
  AST_HOLD: assert property (o_ep_valid && !i_ep_ready |=> o_ep_valid
    && $stable(o_ep_data) && $stable(o_ep_report_end)) else $error("byte dropped");
  AST_HI_NIBBLE: assert property (slot && (off == OFF_X_HI || off == OFF_Y_HI) |->
    o_ep_data[7:4] == 4'h0) else $error("position high nibble set");
  AST_ID_BYTE: assert property (slot && off == OFF_ID |-> o_ep_data[2:1] == 2'h0)
    else $error("reserved id bits set");
  AST_GEOM_OFF: assert property (slot && !geom_r && (off == OFF_X2_LO
    || off == OFF_X2_HI || off >= OFF_Y2_LO) |-> o_ep_data == 8'h00) else $error("reserved set");
  COV_REPORT: cover property (take && o_ep_report_end);
  COV_STALL: cover property (o_ep_valid && !i_ep_ready);
  COV_GEOM_OFF: cover property (slot && !geom_r);
endmodule
bind tch_report_framer tch_report_framer_properties #(.VER_MAJOR(VER_MAJOR),
  .VER_MINOR(VER_MINOR), .BUILD_BCD(BUILD_BCD)) u_chk (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_frame_start(i_frame_start), .i_ep_ready(i_ep_ready),
  .i_touch_geometry_enable(i_touch_geometry_enable), .o_ep_data(o_ep_data),
  .o_ep_valid(o_ep_valid), .o_ep_report_end(o_ep_report_end), .o_ep_addr(o_ep_addr),
  .o_busy(o_busy), .o_generic_in_addr(o_generic_in_addr), .o_version(o_version),
  .o_generic_out_addr(o_generic_out_addr), .o_digitizer_in_eps(o_digitizer_in_eps),
  .o_digitizer_out_eps(o_digitizer_out_eps), .o_full_speed(o_full_speed));

// [verification/touch_report_framer_tb_top.sv]
// Purpose: self-checking bench for the touch report framer
// Assumes: touch table answers from o_touch_idx at once
// Notes: scan tick shortened to 10 cycles
`timescale 1ns/1ps
module touch_report_framer_tb_top;
  import tch_pkg::*;
  // shortened scan tick so that the timestamp moves within a short run
  localparam int SCAN_CYC = 10;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, geom = 1'b0, stall = 1'b0;
  logic [4:0] cnt = 5'h00, idx;
  logic [7:0] data, addr, gin, gout;
  logic [1:0] din, dout;
  logic vld, rdy, rend, fend, busy, fs, ctl;
  logic [15:0] ver;
  logic [9:0] q[$];
  int fail_count = 0, checks_done = 0;
  int cyc = 0;
  initial forever #5 clk = ~clk;
  tch_report_framer #(.SCAN_CYCLES(SCAN_CYC), .VER_MAJOR(4'h2), .VER_MINOR(4'h3),
    .BUILD_BCD(8'h47)) dut (.i_clk_sys(clk), .i_reset(rst), .i_frame_start(start),
    .i_touch_count(cnt), .i_touch_geometry_enable(geom), .i_touch_id(idx + 5'h01),
    .i_in_detect(~idx[0]), .i_x(12'hA00 + 12'(idx)), .i_y(12'h5C0 + 12'(idx)),
    .i_x2(12'h7E0 + 12'(idx)), .i_y2(12'h1B0 + 12'(idx)), .i_width(8'h40 + 8'(idx)),
    .i_height(8'h90 + 8'(idx)), .o_touch_idx(idx), .o_ep_data(data), .o_ep_valid(vld),
    .i_ep_ready(rdy), .o_ep_report_end(rend), .o_ep_frame_end(fend), .o_ep_addr(addr),
    .o_busy(busy), .o_generic_in_addr(gin), .o_generic_out_addr(gout),
    .o_digitizer_in_eps(din), .o_digitizer_out_eps(dout), .o_full_speed(fs),
    .o_ctrl_ep_enable(ctl), .o_version(ver));
  tch_host_model host (.i_clk_sys(clk), .i_stall(stall), .o_ready(rdy));
  always @(posedge clk) if (vld && rdy) q.push_back({fend, rend, data});
  // clock edges out of reset, the base of the expected scan time
  always @(posedge clk) if (!rst) cyc <= cyc + 1;
  // ==========================================================
  // compare and expectation helpers
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  function automatic logic [7:0] exp_b(int r, int b, int n, logic g);
    int k, o;
    logic [11:0] x, y, x2, y2;
    k = r * 5 + (b - 1) / 11;
    o = (b - 1) % 11;
    x = 12'hA00 + 12'(k);
    y = 12'h5C0 + 12'(k);
    x2 = 12'h7E0 + 12'(k);
    y2 = 12'h1B0 + 12'(k);
    if (b == 0) return 8'h01;
    if (b == 58) return (r == (n + 4) / 5 - 1 || n == 0) ? 8'(n) : 8'h00;
    if (k >= n || (!g && (o == 3 || o == 4 || o > 6))) return 8'h00;
    case (o)
      0: return {5'(k + 1), 2'h0, ~k[0]};
      1: return x[7:0];
      2: return {4'h0, x[11:8]};
      3: return x2[7:0];
      4: return {4'h0, x2[11:8]};
      5: return y[7:0];
      6: return {4'h0, y[11:8]};
      7: return y2[7:0];
      8: return {4'h0, y2[11:8]};
      9: return 8'h40 + 8'(k);
      default: return 8'h90 + 8'(k);
    endcase
  endfunction
  task automatic run_frame(input int n, input logic g, input logic s);
    int nr, t, i, sc;
    nr = (n == 0) ? 1 : (n + 4) / 5;
    q.delete();
    #1 stall = s;
    cnt = 5'(n);
    geom = g;
    start = 1'b1;
    // the frame is taken at the coming edge: scan time counts the edges before it
    sc = cyc / SCAN_CYC;
    @(posedge clk);
    #1 start = 1'b0;
    for (t = 0; t < 5000 && q.size() < nr * 59; t++) @(posedge clk);
    if (q.size() < nr * 59)
    begin
      fail_count++;
      $display("Error t=%0t frame incomplete", $time);
    end
    for (i = 0; i < nr * 59; i++)
    begin
      if (i % 59 == 56) chk8(q[i][7:0], sc[7:0]);
      else if (i % 59 == 57) chk8(q[i][7:0], sc[15:8]);
      else chk8(q[i][7:0], exp_b(i / 59, i % 59, n, g));
      chk1(q[i][8], i % 59 == 58);
      chk1(q[i][9], i == nr * 59 - 1);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_static;
    chk8(addr, EP_TOUCH_IN_ADDR);
    chk8(gin, EP_GENERIC_IN_ADDR);
    chk8(gout, EP_GENERIC_OUT_ADDR);
    chk8({4'h0, din, dout}, {4'h0, DIGITIZER_IN_EP_COUNT, DIGITIZER_OUT_EP_COUNT});
    chk1(fs, 1'b1);
    chk1(ctl, 1'b1);
    chk8(ver[15:8], 8'h23);
    chk8(ver[7:0], 8'h47);
    $display("t_static done");
  endtask
  task automatic t_one_geom;
    run_frame(1, 1'b1, 1'b0);
    $display("t_one_geom done");
  endtask
  task automatic t_seven_flat;
    run_frame(7, 1'b0, 1'b1);
    $display("t_seven_flat done");
  endtask
  task automatic t_zero;
    run_frame(0, 1'b1, 1'b0);
    $display("t_zero done");
  endtask
  task automatic t_five_flat;
    run_frame(5, 1'b0, 1'b0);
    $display("t_five_flat done");
  endtask
  task automatic t_max_slow;
    run_frame(31, 1'b1, 1'b1);
    $display("t_max_slow done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    fail_count++;
    $display("Error t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    t_static();
    t_one_geom();
    t_seven_flat();
    t_zero();
    t_five_flat();
    t_max_slow();
    tally_and_finish();
  end
endmodule
